// ==== nvmc_defs.svh ====
// Purpose: constants for the nvm unlock / program / erase controller
// Assumes: 40 MHz core clock, 16-bit special function register bus
// Notes: offsets are the register addresses seen by the core
//
// Overview of operation
// - erase or program starts only after keys 0x55 then 0xaa, then start.
// - data eeprom supports single-word and sixteen-word block operations.
// - data eeprom holds 4K words at addresses 0x7ff000 to 0x7fffff.
// - low and high address registers together address the eeprom location.
// - eeprom write takes about 2 ms; completion is flagged, not assumed.
// - eeprom program or erase runs in background, core keeps running.
// - eeprom read during an operation gives undefined data.
// - software may set the start bit but never clear it.
// - hardware clears the start bit when the operation finishes.
// - write-enable bit must be set to operate; cleared at power-up.
// - error flag sets when external or watchdog reset interrupts a write.
// - low address register keeps its value across an interrupting reset.
// - completion sets the done flag, which stays until software clears it.
// - block erase uses both address registers and control value 4045.
// - table read low in eeprom range returns the addressed stored word.
// - start bit needs write-enable set by an earlier instruction.
// - program flash operation lasts about 2 ms and stalls the core.
// - clearing write-enable mid-run has no effect; hardware clears it only on power-up, external or watchdog reset.
`ifndef NVMC_DEFS_SVH
`define NVMC_DEFS_SVH
`define NVM_ADDR_LOW_OFS 16'h0762
`define NVM_ADDR_HIGH_OFS 16'h0764
`define NVM_CTRL_OFS 16'h0920
`define NVM_KEY_OFS 16'h9940
`define NVM_KEY_FIRST 8'h55
`define NVM_KEY_SECOND 8'haa
`define NVM_WR_BIT 15
`define NVM_WRITE_PERMIT_BIT_BIT 14
`define NVM_INTERRUPTED_WRITE_ERROR_BIT 13
`define NVM_ERASE_BIT 6
`define NVM_OP_MSB 6
`define NVM_CODE_MSB 3
`define NVM_OP_PFLASH_ROW 4'h1
`define NVM_OP_EE_WORD 4'h4
`define NVM_OP_EE_BLOCK 4'h5
`define NVM_OP_EE_MULTI 4'ha
`define NVM_CTRL_RESET 16'h0000
`define NVM_ADDR_RESET 16'h0000
`define NVM_EE_PAGE 12'h7ff
`define NVM_EE_DEPTH 4096
`define NVM_BLOCK_WORDS 16
`define NVM_ERASED_WORD 16'hffff
`define NVM_PROG_TIME_US 2000
`define NVM_CLK_MHZ 40
`define NVM_PROG_CYCLES (`NVM_PROG_TIME_US * `NVM_CLK_MHZ)
`define NVM_TIMER_W 20
`endif

// ==== nvmc_pkg.sv ====
// Purpose: types shared by the nvm controller
// Assumes: nvmc_defs.svh supplies every numeric constant
// Notes: none
package nvmc_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_BUSY} nvmc_state_t;
    typedef enum logic [1:0] {UL_LOCKED, UL_FIRST, UL_OPEN} nvmc_unlock_t;
    typedef enum logic [1:0] {OPK_NONE, OPK_PFLASH, OPK_EE_WORD, OPK_EE_BLOCK}
        nvmc_kind_t;
endpackage : nvmc_pkg

// ==== nvmc_ctrl.sv ====
// Purpose: nvm unlock, program and erase sequencer with data eeprom array
// Assumes: core bus and table strobes are one-cycle pulses, synchronous
// Notes: program flash array and its row latches live outside this block
`timescale 1ns/100ps
`include "nvmc_defs.svh"
module nvmc_ctrl
    import nvmc_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = `NVM_PROG_CYCLES
)
(
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // device resets other than power-up
    input wire logic external_master_reset,
    input wire logic watchdog_timeout,
    // special function register access
    input wire logic [15:0] sfr_addr,
    input wire logic sfr_wr_en,
    input wire logic sfr_rd_en,
    input wire logic [15:0] sfr_wdata,
    output logic [15:0] sfr_rdata_q,
    // table instructions
    input wire logic [23:0] tbl_addr,
    input wire logic table_read_low_insn,
    input wire logic table_write_low_insn,
    input wire logic [15:0] tbl_wdata,
    output logic [15:0] tbl_rdata_q,
    // status toward core and interrupt controller
    input wire logic nvm_done_clear,
    output logic nvm_done_flag_q,
    output logic cpu_stall_q,
    output logic ee_busy_q
);

    localparam logic [`NVM_TIMER_W-1:0] TIMER_LOAD =
        `NVM_TIMER_W'(PROG_CYCLES - 1);
    localparam logic [15:0] CTRL_RST = `NVM_CTRL_RESET;
    localparam logic [15:0] ADDR_RST = `NVM_ADDR_RESET;

    nvmc_state_t state_q;
    nvmc_unlock_t unlock_q;
    nvmc_kind_t run_kind_q;
    logic run_erase_q;
    logic [11:0] run_idx_q;
    logic [`NVM_TIMER_W-1:0] timer_q;
    logic wr_q;
    logic write_permit_bit_q;
    logic interrupted_write_error_q;
    logic [`NVM_OP_MSB:0] op_q;
    logic [15:0] addr_lo_q;
    logic [7:0] addr_hi_q;
    logic [15:0] latch_q [`NVM_BLOCK_WORDS];
    logic [15:0] mem_q [`NVM_EE_DEPTH];

    logic dev_rst;
    logic any_access;
    logic wr_ctrl;
    logic wr_key;
    logic wr_lo;
    logic wr_hi;
    logic key_first;
    logic key_second;
    logic set_start;
    logic start_ok;
    logic finish;
    logic [23:0] full_addr;
    logic tbl_in_ee;
    nvmc_kind_t sel_kind;

    function automatic nvmc_kind_t kind_of(input logic [`NVM_OP_MSB:0] op);
        nvmc_kind_t k;
        k = OPK_NONE;
        case (op[`NVM_CODE_MSB:0])
            `NVM_OP_PFLASH_ROW: k = OPK_PFLASH;
            `NVM_OP_EE_WORD: k = OPK_EE_WORD;
            `NVM_OP_EE_BLOCK: k = OPK_EE_BLOCK;
            `NVM_OP_EE_MULTI: k = OPK_EE_BLOCK;
            default: k = OPK_NONE;
        endcase
        return k;
    endfunction : kind_of

    // external and watchdog resets act synchronously on this block
    assign dev_rst = external_master_reset | watchdog_timeout;
    assign any_access = sfr_wr_en | sfr_rd_en;
    assign wr_ctrl = sfr_wr_en && (sfr_addr == `NVM_CTRL_OFS);
    assign wr_key = sfr_wr_en && (sfr_addr == `NVM_KEY_OFS);
    assign wr_lo = sfr_wr_en && (sfr_addr == `NVM_ADDR_LOW_OFS);
    assign wr_hi = sfr_wr_en && (sfr_addr == `NVM_ADDR_HIGH_OFS);
    assign key_first = wr_key && (sfr_wdata[7:0] == `NVM_KEY_FIRST);
    assign key_second = wr_key && (sfr_wdata[7:0] == `NVM_KEY_SECOND);
    assign set_start = wr_ctrl && sfr_wdata[`NVM_WR_BIT];
    assign full_addr = {addr_hi_q, addr_lo_q};
    assign tbl_in_ee = (tbl_addr[23:12] == `NVM_EE_PAGE);
    assign sel_kind = kind_of(op_q);

    // write-enable must already be set (old value), so one write cannot
    // set both it and the start bit
    always_comb
    begin
        start_ok = set_start && (unlock_q == UL_OPEN) && write_permit_bit_q
            && (state_q == ST_IDLE) && !dev_rst;
        case (sel_kind)
            OPK_PFLASH: start_ok = start_ok;
            OPK_EE_WORD,
            OPK_EE_BLOCK: start_ok = start_ok
                && (full_addr[23:12] == `NVM_EE_PAGE);
            default: start_ok = 1'b0;
        endcase
    end

    assign finish = (state_q == ST_BUSY) && (timer_q == '0);

    // unlock tracker: each access must be the next step or it relocks
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            unlock_q <= UL_LOCKED;
        else if (clk_en)
        begin
            if (dev_rst)
                unlock_q <= UL_LOCKED;
            else if (any_access)
            begin
                if (key_first)
                    unlock_q <= UL_FIRST;
                else if (key_second && unlock_q == UL_FIRST)
                    unlock_q <= UL_OPEN;
                else
                    unlock_q <= UL_LOCKED;
            end
        end
    end

    // operation state and duration timer
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= ST_IDLE;
            timer_q <= '0;
            run_kind_q <= OPK_NONE;
            run_erase_q <= 1'b0;
            run_idx_q <= '0;
        end
        else if (clk_en)
        begin
            if (dev_rst)
                state_q <= ST_IDLE;
            else
            begin
                case (state_q)
                    ST_IDLE:
                    begin
                        if (start_ok)
                        begin
                            state_q <= ST_BUSY;
                            timer_q <= TIMER_LOAD;
                            run_kind_q <= sel_kind;
                            run_erase_q <= op_q[`NVM_ERASE_BIT];
                            run_idx_q <= full_addr[11:0];
                        end
                    end
                    ST_BUSY:
                    begin
                        // write-enable is not looked at here on purpose
                        if (finish)
                            state_q <= ST_IDLE;
                        else
                            timer_q <= timer_q - 1'b1;
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // control register: start, write-enable, error, operation select
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_q <= CTRL_RST[`NVM_WR_BIT];
            write_permit_bit_q <= CTRL_RST[`NVM_WRITE_PERMIT_BIT_BIT];
            interrupted_write_error_q <= CTRL_RST[`NVM_INTERRUPTED_WRITE_ERROR_BIT];
            op_q <= CTRL_RST[`NVM_OP_MSB:0];
        end
        else if (clk_en)
        begin
            if (dev_rst)
            begin
                wr_q <= 1'b0;
                write_permit_bit_q <= 1'b0;
                op_q <= CTRL_RST[`NVM_OP_MSB:0];
                if (state_q == ST_BUSY)
                    interrupted_write_error_q <= 1'b1;
            end
            else
            begin
                if (start_ok)
                    wr_q <= 1'b1;
                else if (finish)
                    wr_q <= 1'b0;
                if (wr_ctrl)
                begin
                    write_permit_bit_q <= sfr_wdata[`NVM_WRITE_PERMIT_BIT_BIT];
                    interrupted_write_error_q <= sfr_wdata[`NVM_INTERRUPTED_WRITE_ERROR_BIT];
                    // selection frozen while running
                    if (state_q == ST_IDLE)
                        op_q <= sfr_wdata[`NVM_OP_MSB:0];
                end
            end
        end
    end

    // address registers; table instructions capture their address
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addr_lo_q <= ADDR_RST;
            addr_hi_q <= ADDR_RST[7:0];
        end
        else if (clk_en && !dev_rst)
        begin
            if (wr_lo)
                addr_lo_q <= sfr_wdata;
            else if ((table_read_low_insn || table_write_low_insn)
                && state_q == ST_IDLE)
                addr_lo_q <= tbl_addr[15:0];
            if (wr_hi)
                addr_hi_q <= sfr_wdata[7:0];
            else if ((table_read_low_insn || table_write_low_insn)
                && state_q == ST_IDLE)
                addr_hi_q <= tbl_addr[23:16];
        end
    end

    // eeprom write latches, loaded by table write low
    generate
        for (genvar i = 0; i < `NVM_BLOCK_WORDS; i++)
        begin : g_latch
            always_ff @(posedge core_clk or negedge rst_b)
            begin
                if (!rst_b)
                    latch_q[i] <= `NVM_ERASED_WORD;
                else if (clk_en && table_write_low_insn && tbl_in_ee
                    && tbl_addr[3:0] == 4'(i))
                    latch_q[i] <= tbl_wdata;
            end
        end
    endgenerate

    // eeprom array; contents are committed only at the end of the
    // operation, so an interrupted write leaves the location unchanged
    always_ff @(posedge core_clk)
    begin
        if (clk_en && finish && !dev_rst)
        begin
            case (run_kind_q)
                OPK_EE_WORD:
                begin
                    if (run_erase_q)
                        mem_q[run_idx_q] <= `NVM_ERASED_WORD;
                    else
                        mem_q[run_idx_q] <= latch_q[run_idx_q[3:0]];
                end
                OPK_EE_BLOCK:
                begin
                    for (int j = 0; j < `NVM_BLOCK_WORDS; j++)
                    begin
                        if (run_erase_q)
                            mem_q[{run_idx_q[11:4], 4'(j)}] <=
                                `NVM_ERASED_WORD;
                        else
                            mem_q[{run_idx_q[11:4], 4'(j)}] <= latch_q[j];
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    // table read data; undefined while an operation runs, given as zero
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            tbl_rdata_q <= '0;
        else if (clk_en && table_read_low_insn)
        begin
            if (tbl_in_ee && state_q == ST_IDLE)
                tbl_rdata_q <= mem_q[tbl_addr[11:0]];
            else
                tbl_rdata_q <= '0;
        end
    end

    // register read data; key register reads as zero
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            sfr_rdata_q <= '0;
        else if (clk_en && sfr_rd_en)
        begin
            case (sfr_addr)
                `NVM_CTRL_OFS: sfr_rdata_q <= {wr_q, write_permit_bit_q, interrupted_write_error_q,
                    6'h00, op_q};
                `NVM_ADDR_LOW_OFS: sfr_rdata_q <= addr_lo_q;
                `NVM_ADDR_HIGH_OFS: sfr_rdata_q <= {8'h00, addr_hi_q};
                default: sfr_rdata_q <= '0;
            endcase
        end
    end

    // done flag: a completion in the clearing cycle still sets it
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            nvm_done_flag_q <= 1'b0;
        else if (clk_en)
        begin
            if (finish && !dev_rst)
                nvm_done_flag_q <= 1'b1;
            else if (nvm_done_clear)
                nvm_done_flag_q <= 1'b0;
        end
    end

    // core stall for program flash, background busy for eeprom
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cpu_stall_q <= 1'b0;
            ee_busy_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (dev_rst || finish)
            begin
                cpu_stall_q <= 1'b0;
                ee_busy_q <= 1'b0;
            end
            else if (start_ok)
            begin
                cpu_stall_q <= (sel_kind == OPK_PFLASH);
                ee_busy_q <= (sel_kind != OPK_PFLASH);
            end
        end
    end

endmodule : nvmc_ctrl

// ==== nvmc_checker.sv ====
// Purpose: port checker for nvmc_ctrl
// Assumes: mirrored key and write-permit state moves only with clk_en
// Notes: sync resets abort an operation, so length checks skip them
`timescale 1ns/100ps
`include "nvmc_defs.svh"
module nvmc_checker
    import nvmc_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = 12
)
(
    // clock and resets
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic external_master_reset,
    input wire logic watchdog_timeout,
    // register and table access
    input wire logic [15:0] sfr_addr,
    input wire logic sfr_wr_en,
    input wire logic sfr_rd_en,
    input wire logic [15:0] sfr_wdata,
    input wire logic table_read_low_insn,
    input wire logic [15:0] tbl_rdata_q,
    // status
    input wire logic nvm_done_clear,
    input wire logic nvm_done_flag_q,
    input wire logic cpu_stall_q,
    input wire logic ee_busy_q
);
    logic srst, run, kw, cw;
    logic [19:0] cnt_q;
    logic [1:0] key_q;
    logic write_permit_bit_q, ok_q;
    assign srst = external_master_reset | watchdog_timeout;
    assign run = ee_busy_q | cpu_stall_q;
    assign kw = sfr_wr_en && sfr_addr == `NVM_KEY_OFS;
    assign cw = sfr_wr_en && sfr_addr == `NVM_CTRL_OFS;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge core_clk or negedge rst_b)
        if (!rst_b)
            cnt_q <= 20'h0;
        else
            cnt_q <= run ? cnt_q + {19'h0, clk_en} : 20'h0;
    always_ff @(posedge core_clk or negedge rst_b)
        if (!rst_b)
            write_permit_bit_q <= 1'b0;
        else if (!clk_en)
            write_permit_bit_q <= write_permit_bit_q;
        else if (srst)
            write_permit_bit_q <= 1'b0;
        else if (cw)
            write_permit_bit_q <= sfr_wdata[14];
    // idle cycles keep the unlock; another access or a sync reset cancels it
    always_ff @(posedge core_clk or negedge rst_b)
        if (!rst_b)
            key_q <= 2'h0;
        else if (!clk_en)
            key_q <= key_q;
        else if (srst)
            key_q <= 2'h0;
        else if (kw && sfr_wdata[7:0] == `NVM_KEY_FIRST)
            key_q <= 2'h1;
        else if (kw && key_q == 2'h1 && sfr_wdata[7:0] == `NVM_KEY_SECOND)
            key_q <= 2'h2;
        else if (sfr_wr_en | sfr_rd_en)
            key_q <= 2'h0;
    always_ff @(posedge core_clk or negedge rst_b)
        if (!rst_b)
            ok_q <= 1'b0;
        else
            ok_q <= clk_en && cw && sfr_wdata[15] && key_q == 2'h2
                && write_permit_bit_q && !srst;
    AST_START_UNLOCKED: assert property ($rose(run) |-> ok_q)
        else $error("operation started without unlock and permit");
    AST_OP_LENGTH: assert property (
        $fell(run) && !$past(srst) |-> cnt_q == PROG_CYCLES)
        else $error("operation length wrong");
    AST_DONE_ON_END: assert property (
        $fell(run) && !$past(srst) |-> nvm_done_flag_q)
        else $error("done flag missing at end");
    AST_DONE_CAUSE: assert property (
        $rose(nvm_done_flag_q) |-> $fell(run))
        else $error("done flag without completion");
    AST_DONE_STICKY: assert property (
        nvm_done_flag_q && !nvm_done_clear && !srst |=> nvm_done_flag_q)
        else $error("done flag dropped by itself");
    AST_EE_NO_STALL: assert property (ee_busy_q |-> !cpu_stall_q)
        else $error("eeprom operation stalls core");
    AST_BUSY_READ: assert property (
        table_read_low_insn && ee_busy_q && clk_en |=>
        tbl_rdata_q == 16'h0000)
        else $error("busy read data not zero");
    AST_ABORT: assert property (srst && run && clk_en |=> !run[*2])
        else $error("reset did not abort operation");
    cover property ($fell(ee_busy_q) && nvm_done_flag_q);
    cover property ($fell(cpu_stall_q));
    cover property (srst && run);
endmodule : nvmc_checker
bind nvmc_ctrl nvmc_checker #(.PROG_CYCLES(PROG_CYCLES)) nvmc_checker_i (
    .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
    .external_master_reset(external_master_reset),
    .watchdog_timeout(watchdog_timeout), .sfr_addr(sfr_addr),
    .sfr_wr_en(sfr_wr_en), .sfr_rd_en(sfr_rd_en), .sfr_wdata(sfr_wdata),
    .table_read_low_insn(table_read_low_insn), .tbl_rdata_q(tbl_rdata_q),
    .nvm_done_clear(nvm_done_clear), .nvm_done_flag_q(nvm_done_flag_q),
    .cpu_stall_q(cpu_stall_q), .ee_busy_q(ee_busy_q));

// ==== nvmc_core_model.sv ====
// Purpose: core model issuing register and table accesses
// Assumes: one access at a time, driven just after the rising edge
// Notes: idle address and data lines show the inverse of the last value
`timescale 1ns/100ps
`include "nvmc_defs.svh"
module nvmc_core_model
(
    // clock
    input wire logic core_clk,
    // register access
    output logic [15:0] sfr_addr,
    output logic sfr_wr_en,
    output logic sfr_rd_en,
    output logic [15:0] sfr_wdata,
    input wire logic [15:0] sfr_rdata_q,
    // table access
    output logic [23:0] tbl_addr,
    output logic table_read_low_insn,
    output logic table_write_low_insn,
    output logic [15:0] tbl_wdata,
    input wire logic [15:0] tbl_rdata_q
);
    initial
    begin
        {sfr_addr, sfr_wr_en, sfr_rd_en, sfr_wdata} = 34'h0;
        {tbl_addr, table_read_low_insn, table_write_low_insn} = 26'h0;
        tbl_wdata = 16'h0000;
    end
    task automatic sfr(input logic [15:0] a, d, input logic rd,
        output logic [15:0] q);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr_en <= !rd;
        sfr_rd_en <= rd;
        @(posedge core_clk);
        {sfr_wr_en, sfr_rd_en} <= 2'h0;
        sfr_addr <= ~a;
        sfr_wdata <= ~d;
        #1 q = sfr_rdata_q;
    endtask : sfr
    task automatic tbl(input logic [23:0] a, input logic [15:0] d,
        input logic rd, output logic [15:0] q);
        @(posedge core_clk);
        tbl_addr <= a;
        tbl_wdata <= d;
        table_write_low_insn <= !rd;
        table_read_low_insn <= rd;
        @(posedge core_clk);
        {table_write_low_insn, table_read_low_insn} <= 2'h0;
        tbl_addr <= ~a;
        tbl_wdata <= ~d;
        #1 q = tbl_rdata_q;
    endtask : tbl
    // no interrupt can split the sequence: the model runs it uninterrupted
    task automatic start_op(input logic [15:0] c);
        logic [15:0] q;
        sfr(`NVM_CTRL_OFS, c, 1'b0, q);
        sfr(`NVM_KEY_OFS, 16'h0055, 1'b0, q);
        sfr(`NVM_KEY_OFS, 16'h00aa, 1'b0, q);
        sfr(`NVM_CTRL_OFS, c | 16'h8000, 1'b0, q);
        repeat (2) @(posedge core_clk);
        #1;
    endtask : start_op
endmodule : nvmc_core_model

// ==== test_nvm_unlock_program_erase_ctrl.sv ====
// Purpose: self-checking bench for nvmc_ctrl
// Assumes: short operation time through the cycle parameter
// Notes: eeprom contents are unknown until first erased
`timescale 1ns/100ps
`include "nvmc_defs.svh"
module test_nvm_unlock_program_erase_ctrl;
    logic core_clk = 1'b0, rst_b = 1'b0, emr = 1'b0, wdt = 1'b0;
    logic done_clr = 1'b0, ce = 1'b1;
    logic [15:0] sa, sd, sq, ta_d, tq, q, dat;
    logic [23:0] ta, a;
    logic sw, sr, trd, twr, done, stall, busy;
    logic [15:0] blk [16];
    int num_errors = 0, n_tests = 0, cyc = 0;
    always #12.5 core_clk = ~core_clk;
    nvmc_ctrl #(.PROG_CYCLES(12)) nvmc_ctrl_i (.core_clk(core_clk),
        .rst_b(rst_b), .clk_en(ce), .external_master_reset(emr),
        .watchdog_timeout(wdt), .sfr_addr(sa), .sfr_wr_en(sw),
        .sfr_rd_en(sr), .sfr_wdata(sd), .sfr_rdata_q(sq), .tbl_addr(ta),
        .table_read_low_insn(trd), .table_write_low_insn(twr),
        .tbl_wdata(ta_d), .tbl_rdata_q(tq), .nvm_done_clear(done_clr),
        .nvm_done_flag_q(done), .cpu_stall_q(stall), .ee_busy_q(busy));
    nvmc_core_model nvmc_core_model_i (.core_clk(core_clk), .sfr_addr(sa),
        .sfr_wr_en(sw), .sfr_rd_en(sr), .sfr_wdata(sd), .sfr_rdata_q(sq),
        .tbl_addr(ta), .table_read_low_insn(trd),
        .table_write_low_insn(twr), .tbl_wdata(ta_d), .tbl_rdata_q(tq));
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize
    task automatic chk(input logic [15:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] ad, d);
        nvmc_core_model_i.sfr(ad, d, 1'b0, q);
    endtask : wr
    task automatic rd(input logic [15:0] ad);
        nvmc_core_model_i.sfr(ad, 16'h0000, 1'b1, q);
    endtask : rd
    task automatic wait_done();
        for (int i = 0; i < 40 && done !== 1'b1; i++)
            @(posedge core_clk);
        #1 chk({15'h0, done}, 16'h0001);
        @(posedge core_clk);
        done_clr <= 1'b1;
        @(posedge core_clk);
        done_clr <= 1'b0;
        #1 chk({15'h0, done}, 16'h0000);
    endtask : wait_done
    function automatic logic [23:0] ee(input logic [11:0] i);
        return {`NVM_EE_PAGE, i};
    endfunction : ee
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            summarize();
        end
    end
    initial
    begin
        void'($urandom(34195));
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(`NVM_CTRL_OFS);
        chk(q, `NVM_CTRL_RESET);
        $display("test reset done");
        repeat (3)
        begin
            a = ee($urandom_range(4095));
            dat = $urandom;
            nvmc_core_model_i.tbl(a, dat, 1'b0, q);
            nvmc_core_model_i.start_op(16'h4044);
            wait_done();
            nvmc_core_model_i.start_op(16'h4004);
            nvmc_core_model_i.tbl(a, 16'h0000, 1'b1, q);
            chk(q, 16'h0000);
            wr(`NVM_CTRL_OFS, 16'h0000);
            chk({15'h0, busy}, 16'h0001);
            rd(`NVM_CTRL_OFS);
            chk(q, 16'h8004);
            wait_done();
            rd(`NVM_CTRL_OFS);
            chk(q, 16'h0004);
            nvmc_core_model_i.tbl(a, 16'h0000, 1'b1, q);
            chk(q, dat);
        end
        $display("test word done");
        a = ee($urandom_range(4095) & 12'hff0);
        wr(`NVM_ADDR_HIGH_OFS, {8'h00, a[23:16]});
        wr(`NVM_ADDR_LOW_OFS, a[15:0]);
        nvmc_core_model_i.start_op(16'h4045);
        wait_done();
        for (int i = 0; i < 16; i++)
        begin
            nvmc_core_model_i.tbl(a + i, 16'h0000, 1'b1, q);
            chk(q, `NVM_ERASED_WORD);
            blk[i] = $urandom;
            nvmc_core_model_i.tbl(a + i, blk[i], 1'b0, q);
        end
        nvmc_core_model_i.start_op(16'h400a);
        wait_done();
        for (int i = 0; i < 16; i++)
        begin
            nvmc_core_model_i.tbl(a + i, 16'h0000, 1'b1, q);
            chk(q, blk[i]);
        end
        $display("test block done");
        nvmc_core_model_i.start_op(16'h0004);
        chk({15'h0, busy}, 16'h0000);
        wr(`NVM_KEY_OFS, 16'h0055);
        wr(`NVM_KEY_OFS, 16'h00aa);
        wr(`NVM_CTRL_OFS, 16'hc004);
        #1 chk({15'h0, busy}, 16'h0000);
        wr(`NVM_CTRL_OFS, 16'h4004);
        wr(`NVM_KEY_OFS, 16'h0055);
        rd(`NVM_CTRL_OFS);
        wr(`NVM_KEY_OFS, 16'h00aa);
        wr(`NVM_CTRL_OFS, 16'hc004);
        #1 chk({15'h0, busy}, 16'h0000);
        wr(`NVM_KEY_OFS, 16'h00aa);
        wr(`NVM_KEY_OFS, 16'h0055);
        wr(`NVM_CTRL_OFS, 16'hc004);
        #1 chk({15'h0, busy}, 16'h0000);
        $display("test lock done");
        for (int k = 0; k < 2; k++)
        begin
            dat = $urandom;
            // stay inside the eeprom page, else the start is refused
            dat[15:12] = 4'hf;
            wr(`NVM_ADDR_HIGH_OFS, 16'h007f);
            wr(`NVM_ADDR_LOW_OFS, dat);
            nvmc_core_model_i.start_op(16'h4044);
            @(posedge core_clk);
            emr <= (k == 0);
            wdt <= (k == 1);
            @(posedge core_clk);
            {emr, wdt} <= 2'h0;
            rd(`NVM_CTRL_OFS);
            chk(q, 16'h2000);
            rd(`NVM_ADDR_LOW_OFS);
            chk(q, dat);
        end
        $display("test abort done");
        nvmc_core_model_i.start_op(16'h4001);
        chk({15'h0, stall}, 16'h0001);
        // three frozen edges push the end three cycles later
        @(posedge core_clk);
        ce <= 1'b0;
        repeat (3) @(posedge core_clk);
        ce <= 1'b1;
        repeat (6) @(posedge core_clk);
        #1 chk({15'h0, stall}, 16'h0001);
        wait_done();
        $display("test stall done");
        summarize();
    end
endmodule : test_nvm_unlock_program_erase_ctrl
